// ### rhd_cmd_decode.sv
// Command code decoder with write gating by controller state.
`include "rhd_consts.svh"

module rhd_cmd_decode (
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire rhd_pkg::rhd_usb_state_t usb_state_i,
  rhd_cmd_if.dec cmd
);

  logic oper;

  always_comb begin
    oper = (usb_state_i == rhd_pkg::RHD_ST_OPERATIONAL);
    cmd.rd_a = 1'b0;
    cmd.wr_a = 1'b0;
    cmd.fwd = 1'b0;
    cmd.refused = 1'b0;
    cmd.unknown = 1'b0;
    if (cmd_valid_i) begin
      unique case (cmd_code_i)
        `RHD_CMD_RD_DESC_A: cmd.rd_a = 1'b1;
        `RHD_CMD_WR_DESC_A: cmd.wr_a = 1'b1;
        `RHD_CMD_WR_DESC_B: cmd.fwd = 1'b1;
        `RHD_CMD_WR_STATUS, `RHD_CMD_WR_PORT1, `RHD_CMD_WR_PORT2: begin
          cmd.fwd = oper;
          cmd.refused = !oper;
        end
        default: cmd.unknown = 1'b1;
      endcase
    end
  end

endmodule

// ### rhd_cmd_if.sv
// Decoded command strobes passed from the decoder to the register block.
interface rhd_cmd_if;
  logic rd_a;
  logic wr_a;
  logic fwd;
  logic refused;
  logic unknown;

  modport dec (output rd_a, output wr_a, output fwd, output refused, output unknown);
  modport regs (input rd_a, input wr_a, input fwd, input refused, input unknown);
endinterface

// ### rhd_consts.svh
// Constants of the root hub descriptor register block.
`ifndef RHD_CONSTS_SVH
`define RHD_CONSTS_SVH

// ****************************************
// Command codes
// ****************************************
`define RHD_CMD_RD_DESC_A 8'h12
`define RHD_CMD_WR_DESC_A 8'h92
`define RHD_CMD_WR_DESC_B 8'h93
`define RHD_CMD_WR_STATUS 8'h94
`define RHD_CMD_WR_PORT1 8'h95
`define RHD_CMD_WR_PORT2 8'h96

// ****************************************
// Field positions
// ****************************************
`define RHD_POS_DELAY_LO 24
`define RHD_POS_DELAY_HI 31
`define RHD_POS_NO_OVERCURRENT_REPORT 12
`define RHD_POS_OVERCURRENT_SCOPE_SELECT 11
`define RHD_POS_DT 10
`define RHD_POS_NPS 9
`define RHD_POS_PSM 8
`define RHD_POS_NDP_LO 0
`define RHD_POS_NDP_HI 1

// ****************************************
// Reset values
// ****************************************
`define RHD_RST_DELAY 8'h01
`define RHD_RST_NO_OVERCURRENT_REPORT 1'h0
`define RHD_RST_NPS 1'h0
`define RHD_RST_PSM 1'h1
`define RHD_RST_OVERCURRENT_SCOPE_SELECT `RHD_RST_PSM
`define RHD_RST_NDP 2'h2

// ****************************************
// Timing
// ****************************************
`define RHD_DELAY_UNIT_MS 2
`define RHD_CLK_MHZ 100
`define RHD_DELAY_UNIT_CYC (`RHD_DELAY_UNIT_MS * 1000 * `RHD_CLK_MHZ)

`endif

// ### rhd_pkg.sv
// Types of the root hub descriptor register block.
package rhd_pkg;

  typedef enum logic [1:0] {
    RHD_ST_RESET = 2'h0,
    RHD_ST_RESUME = 2'h1,
    RHD_ST_OPERATIONAL = 2'h2,
    RHD_ST_SUSPEND = 2'h3
  } rhd_usb_state_t;

endpackage

// ### rhd_regs.sv
// Root hub first descriptor register and root hub write gating.
//
// Function
// - Five 32-bit root hub registers, each accessed only as a whole double word.
// - Descriptor writes always accepted; status and port writes only when operational.
// - First descriptor register read with code 12h, written with code 92h.
// - Bits 31:24 hold power-good delay in 2 ms units before port access.
// - Bit 12 set means no overcurrent reporting; clear defers to bit 11.
// - Bit 11 selects global (0) or per-port (1) overcurrent reporting.
// - On reset the overcurrent scope bit equals the power switch scope bit.
// - Bit 10 is read-only and always reads zero: not a compound device.
// - Delay, overcurrent, power and port count fields reset to chosen values.
// - Bit 9 selects switched port power (0) or always powered ports (1).
// - Bit 8, when bit 9 clear, selects ganged (0) or per-port (1) power.
// - Read-only bits 1:0 report downstream port count, at most two.
`include "rhd_consts.svh"

module rhd_regs (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [31:0] wdata_i,
  input wire rhd_pkg::rhd_usb_state_t usb_state_i,
  output logic [31:0] rdata_o,
  output logic rdata_valid_o,
  output logic cmd_refused_o,
  output logic cmd_unknown_o,
  output logic fwd_wr_o,
  output logic [7:0] fwd_code_o,
  output logic [31:0] fwd_data_o,
  output logic [7:0] power_good_delay_o,
  output logic [31:0] power_good_cycles_o,
  output logic oc_global_o,
  output logic oc_per_port_o,
  output logic always_powered_o,
  output logic power_per_port_o,
  output logic [1:0] downstream_port_count_o
);

  // ****************************************
  // Command decode
  // ****************************************
  rhd_cmd_if cmd ();

  rhd_cmd_decode u_dec (
    .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i),
    .usb_state_i(usb_state_i),
    .cmd(cmd)
  );

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] power_good_delay;
  logic no_overcurrent_report;
  logic overcurrent_scope_select;
  logic always_powered;
  logic power_switch_scope;
  logic [1:0] downstream_port_count;
  logic [7:0] next_power_good_delay;
  logic next_no_overcurrent_report;
  logic next_overcurrent_scope_select;
  logic next_always_powered;
  logic next_power_switch_scope;
  logic [31:0] cur_word;

  always_comb begin
    cur_word = 32'h0000_0000;
    cur_word[`RHD_POS_DELAY_HI:`RHD_POS_DELAY_LO] = power_good_delay;
    cur_word[`RHD_POS_NO_OVERCURRENT_REPORT] = no_overcurrent_report;
    cur_word[`RHD_POS_OVERCURRENT_SCOPE_SELECT] = overcurrent_scope_select;
    cur_word[`RHD_POS_DT] = 1'b0;
    cur_word[`RHD_POS_NPS] = always_powered;
    cur_word[`RHD_POS_PSM] = power_switch_scope;
    cur_word[`RHD_POS_NDP_HI:`RHD_POS_NDP_LO] = downstream_port_count;
  end

  always_comb begin
    next_power_good_delay = power_good_delay;
    next_no_overcurrent_report = no_overcurrent_report;
    next_overcurrent_scope_select = overcurrent_scope_select;
    next_always_powered = always_powered;
    next_power_switch_scope = power_switch_scope;
    if (cmd.wr_a) begin
      next_power_good_delay = wdata_i[`RHD_POS_DELAY_HI:`RHD_POS_DELAY_LO];
      next_no_overcurrent_report = wdata_i[`RHD_POS_NO_OVERCURRENT_REPORT];
      next_overcurrent_scope_select = wdata_i[`RHD_POS_OVERCURRENT_SCOPE_SELECT];
      next_always_powered = wdata_i[`RHD_POS_NPS];
      next_power_switch_scope = wdata_i[`RHD_POS_PSM];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      power_good_delay <= `RHD_RST_DELAY;
      no_overcurrent_report <= `RHD_RST_NO_OVERCURRENT_REPORT;
      overcurrent_scope_select <= `RHD_RST_OVERCURRENT_SCOPE_SELECT;
      always_powered <= `RHD_RST_NPS;
      power_switch_scope <= `RHD_RST_PSM;
      downstream_port_count <= `RHD_RST_NDP;
    end else begin
      power_good_delay <= next_power_good_delay;
      no_overcurrent_report <= next_no_overcurrent_report;
      overcurrent_scope_select <= next_overcurrent_scope_select;
      always_powered <= next_always_powered;
      power_switch_scope <= next_power_switch_scope;
      downstream_port_count <= downstream_port_count;
    end
  end

  // ****************************************
  // Answers and decoded outputs
  // ****************************************
  logic [31:0] next_rdata;
  logic [31:0] next_cycles;

  always_comb begin
    next_rdata = cmd.rd_a ? cur_word : 32'h0000_0000;
    next_cycles = 32'({24'h00_0000, next_power_good_delay}
      * `RHD_DELAY_UNIT_CYC);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 32'h0000_0000;
      rdata_valid_o <= 1'b0;
      cmd_refused_o <= 1'b0;
      cmd_unknown_o <= 1'b0;
      fwd_wr_o <= 1'b0;
      fwd_code_o <= 8'h00;
      fwd_data_o <= 32'h0000_0000;
      power_good_delay_o <= `RHD_RST_DELAY;
      // Decoded outputs take the values of the reset word, so no false change follows reset.
      power_good_cycles_o <= 32'(`RHD_RST_DELAY * `RHD_DELAY_UNIT_CYC);
      oc_global_o <= !`RHD_RST_NO_OVERCURRENT_REPORT && !`RHD_RST_OVERCURRENT_SCOPE_SELECT;
      oc_per_port_o <= !`RHD_RST_NO_OVERCURRENT_REPORT && `RHD_RST_OVERCURRENT_SCOPE_SELECT;
      always_powered_o <= `RHD_RST_NPS;
      power_per_port_o <= !`RHD_RST_NPS && `RHD_RST_PSM;
      downstream_port_count_o <= `RHD_RST_NDP;
    end else begin
      rdata_o <= next_rdata;
      rdata_valid_o <= cmd.rd_a;
      cmd_refused_o <= cmd.refused;
      cmd_unknown_o <= cmd.unknown;
      fwd_wr_o <= cmd.fwd;
      fwd_code_o <= cmd.fwd ? cmd_code_i : 8'h00;
      fwd_data_o <= cmd.fwd ? wdata_i : 32'h0000_0000;
      power_good_delay_o <= next_power_good_delay;
      power_good_cycles_o <= next_cycles;
      oc_global_o <= !next_no_overcurrent_report && !next_overcurrent_scope_select;
      oc_per_port_o <= !next_no_overcurrent_report && next_overcurrent_scope_select;
      always_powered_o <= next_always_powered;
      power_per_port_o <= !next_always_powered && next_power_switch_scope;
      downstream_port_count_o <= downstream_port_count;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_READ_ANSWER: assert property (
    (cmd_valid_i && cmd_code_i == `RHD_CMD_RD_DESC_A) |=> rdata_valid_o && rdata_o == $past(cur_word))
    else $error("Descriptor read not answered next cycle.");
  AST_WRITE_ANY_STATE: assert property (
    (cmd_valid_i && cmd_code_i == `RHD_CMD_WR_DESC_A) |=>
      power_good_delay == $past(wdata_i[31:24]) && power_switch_scope == $past(wdata_i[8]))
    else $error("Descriptor write not stored.");
  AST_GATED_WRITE: assert property (
    (cmd_valid_i && cmd_code_i == `RHD_CMD_WR_STATUS && usb_state_i != rhd_pkg::RHD_ST_OPERATIONAL)
      |=> cmd_refused_o && !fwd_wr_o)
    else $error("Status write accepted outside operational state.");
  AST_DT_ZERO: assert property (
    rdata_valid_o |-> !rdata_o[`RHD_POS_DT])
    else $error("Compound device bit read as one.");
  AST_RESERVED_ZERO: assert property (
    rdata_valid_o |-> (rdata_o & 32'h00ff_e4fc) == 32'h0000_0000)
    else $error("Reserved bits read nonzero.");
  AST_NO_OC: assert property (
    no_overcurrent_report ##1 no_overcurrent_report |-> !oc_global_o && !oc_per_port_o)
    else $error("Overcurrent reporting active while disabled.");
  AST_OC_SCOPE: assert property (
    (!no_overcurrent_report && overcurrent_scope_select) ##1
      (!no_overcurrent_report && overcurrent_scope_select) |-> oc_per_port_o && !oc_global_o)
    else $error("Overcurrent scope not per-port.");
  AST_RESET_SCOPE: assert property (
    $fell(srst_i) |-> overcurrent_scope_select == power_switch_scope)
    else $error("Overcurrent scope differs from power scope after reset.");
  AST_PORT_COUNT: assert property (
    downstream_port_count <= 2'h2 && $stable(downstream_port_count))
    else $error("Port count changed or above two.");
  AST_POWER_SCOPE: assert property (
    always_powered ##1 always_powered |-> always_powered_o && !power_per_port_o)
    else $error("Per-port power reported while always powered.");
  AST_OC_GLOBAL: assert property (
    (!no_overcurrent_report && !overcurrent_scope_select) ##1
      (!no_overcurrent_report && !overcurrent_scope_select) |-> oc_global_o && !oc_per_port_o)
    else $error("Overcurrent scope not global.");
  AST_DELAY_CYCLES: assert property (
    power_good_cycles_o == 32'({24'h00_0000, power_good_delay_o} * `RHD_DELAY_UNIT_CYC))
    else $error("Power-good cycle count does not match delay byte.");
  AST_DELAY_OUT: assert property (
    (cmd_valid_i && cmd_code_i == `RHD_CMD_WR_DESC_A) |=>
      power_good_delay_o == $past(wdata_i[31:24]))
    else $error("Delay byte output not updated after write.");
  AST_WRITE_SILENT: assert property (
    (cmd_valid_i && cmd_code_i == `RHD_CMD_WR_DESC_A) |=>
      !rdata_valid_o && !fwd_wr_o && !cmd_refused_o && !cmd_unknown_o)
    else $error("Descriptor write produced an answer pulse.");
  AST_FWD_DESC_B: assert property (
    (cmd_valid_i && cmd_code_i == `RHD_CMD_WR_DESC_B) |=> fwd_wr_o && !cmd_refused_o &&
      fwd_code_o == `RHD_CMD_WR_DESC_B && fwd_data_o == $past(wdata_i))
    else $error("Second descriptor write not forwarded.");
  AST_OPER_WRITE: assert property (
    (cmd_valid_i && cmd_code_i == `RHD_CMD_WR_PORT1 &&
      usb_state_i == rhd_pkg::RHD_ST_OPERATIONAL) |=> fwd_wr_o && !cmd_refused_o)
    else $error("Port write refused in operational state.");

endmodule

// ### testbench.sv
// Self-checking testbench of the root hub descriptor register block.
`include "rhd_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_code_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  rhd_pkg::rhd_usb_state_t usb_state_i = rhd_pkg::RHD_ST_RESET;
  logic [31:0] rdata_o, fwd_data_o, power_good_cycles_o, rd_word, fwd_word;
  logic [7:0] fwd_code_o, power_good_delay_o, fwd_code;
  logic rdata_valid_o, cmd_refused_o, cmd_unknown_o, fwd_wr_o, oc_global_o, oc_per_port_o;
  logic always_powered_o, power_per_port_o, got_rd, got_fwd, got_ref, got_unk, ok;
  logic [1:0] downstream_port_count_o;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;

  rhd_regs dut_u (.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .wdata_i(wdata_i), .usb_state_i(usb_state_i),
    .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .cmd_refused_o(cmd_refused_o),
    .cmd_unknown_o(cmd_unknown_o), .fwd_wr_o(fwd_wr_o), .fwd_code_o(fwd_code_o),
    .fwd_data_o(fwd_data_o), .power_good_delay_o(power_good_delay_o),
    .power_good_cycles_o(power_good_cycles_o), .oc_global_o(oc_global_o),
    .oc_per_port_o(oc_per_port_o), .always_powered_o(always_powered_o),
    .power_per_port_o(power_per_port_o), .downstream_port_count_o(downstream_port_count_o));

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  always #5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Gathers every answer pulse seen within three cycles of the taking edge.
  task automatic collect();
    got_rd = 1'b0;
    got_fwd = 1'b0;
    got_ref = 1'b0;
    got_unk = 1'b0;
    repeat (3) @(negedge clk_i) begin
      if (rdata_valid_o === 1'b1) begin
        got_rd = 1'b1;
        rd_word = rdata_o;
      end
      if (fwd_wr_o === 1'b1) begin
        got_fwd = 1'b1;
        fwd_word = fwd_data_o;
        fwd_code = fwd_code_o;
      end
      if (cmd_refused_o === 1'b1) got_ref = 1'b1;
      if (cmd_unknown_o === 1'b1) got_unk = 1'b1;
    end
  endtask

  task automatic cmd(input logic [7:0] code, input logic [31:0] data);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_code_i <= code;
    wdata_i <= data;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    collect();
  endtask

  task automatic rd_chk(input logic [31:0] exp);
    cmd(`RHD_CMD_RD_DESC_A, 32'h0000_0000);
    chk("rd_valid", 32'(1'b1), 32'(got_rd));
    chk("rdata", exp, rd_word);
  endtask

  // Expected: oc_global, oc_per_port, always_powered, power_per_port, count, delay.
  task automatic outs_chk(input logic [13:0] exp);
    chk("decoded", 32'(exp), 32'({oc_global_o, oc_per_port_o, always_powered_o,
      power_per_port_o, downstream_port_count_o, power_good_delay_o}));
    chk("cycles", 32'(exp[7:0]) * `RHD_DELAY_UNIT_CYC, power_good_cycles_o);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    rd_chk(32'h0100_0902);
    outs_chk({4'h5, 2'h2, 8'h01});
    cmd(`RHD_CMD_WR_DESC_A, 32'hFFFF_FFFF);
    rd_chk(32'hFF00_1B02);
    outs_chk({4'h2, 2'h2, 8'hFF});
    cmd(`RHD_CMD_WR_DESC_A, 32'h0000_0000);
    rd_chk(32'h0000_0002);
    outs_chk({4'h8, 2'h2, 8'h00});
    cmd(`RHD_CMD_WR_DESC_A, 32'h0300_0900);
    outs_chk({4'h5, 2'h2, 8'h03});
    cmd(`RHD_CMD_WR_DESC_A, 32'h0000_1200);
    outs_chk({4'h2, 2'h2, 8'h00});
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_code_i <= `RHD_CMD_WR_DESC_A;
    wdata_i <= 32'h7700_0003;
    @(posedge clk_i);
    cmd_code_i <= `RHD_CMD_RD_DESC_A;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    collect();
    chk("rd_valid_b2b", 32'(1'b1), 32'(got_rd));
    chk("rdata_b2b", 32'h7700_0002, rd_word);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      usb_state_i <= rhd_pkg::rhd_usb_state_t'(s[1:0]);
      cmd(`RHD_CMD_WR_DESC_A, {6'h00, s[1:0], 24'h00_0800});
      rd_chk({6'h00, s[1:0], 24'h00_0802});
      for (int c = 8'h93; c <= 8'h96; c++) begin
        ok = (c == 8'h93) || (s == 2);
        cmd(c[7:0], {c[7:0], 24'hA5_5A3C});
        chk("fwd_wr", 32'(ok), 32'(got_fwd));
        chk("refused", 32'(!ok), 32'(got_ref));
        if (ok) chk("fwd_data", {c[7:0], 24'hA5_5A3C}, fwd_word);
        if (ok) chk("fwd_code", 32'(c[7:0]), 32'(fwd_code));
      end
    end
    cmd(8'h13, 32'h0000_0000);
    chk("unknown", 32'(2'b10), 32'({got_unk, got_rd}));
    do_reset();
    rd_chk(32'h0100_0902);
    print_verdict();
  end
endmodule
